/* File: logic/spcs_fifo.sv */
/*
 * spcs_fifo: small synchronous FIFO with valid/ready on both sides.
 * Assumes one clock, synchronous active-low reset, depth a power of two.
 */
`timescale 1ns/1ns
module spcs_fifo #(
	parameter int W  = 8,
	parameter int D  = 16,
	parameter int AW = 4
) (
	// clock and reset
	input  wire logic         clk_in,
	input  wire logic         rst_n_in,
	// filling side
	input  wire logic         in_valid_in,
	input  wire logic [W-1:0] in_data_in,
	output logic              in_ready_out,
	// draining side
	output logic              out_valid_out,
	output logic [W-1:0]      out_data_out,
	input  wire logic         out_ready_in
);
	logic [W-1:0]  mem_q [D];
	logic [AW-1:0] wr_ptr_q;
	logic [AW-1:0] rd_ptr_q;
	logic [AW:0]   cnt_q;
	logic [AW:0]   cnt_d;
	logic          push;
	logic          load;

	// head word moves into the output register when that register frees up
	assign push = in_valid_in & in_ready_out;
	assign load = (cnt_q != '0) && (!out_valid_out || out_ready_in);

	always_comb begin
		cnt_d = cnt_q;
		if (push && !load) begin
			cnt_d = cnt_q + (AW+1)'(1);
		end else if (load && !push) begin
			cnt_d = cnt_q - (AW+1)'(1);
		end
	end

	// storage, no reset needed
	always_ff @(posedge clk_in) begin
		if (push) begin
			mem_q[wr_ptr_q] <= in_data_in;
		end
	end

	// pointers, count and a registered full flag
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			wr_ptr_q     <= '0;
			rd_ptr_q     <= '0;
			cnt_q        <= '0;
			in_ready_out <= 1'b0;
		end else begin
			if (push) begin
				wr_ptr_q <= wr_ptr_q + AW'(1);
			end
			if (load) begin
				rd_ptr_q <= rd_ptr_q + AW'(1);
			end
			cnt_q        <= cnt_d;
			// the output register holds one word, so the memory stops one short of D
			in_ready_out <= (cnt_d < (AW+1)'(D - 1));
		end
	end

	// read data always leaves from a register
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			out_valid_out <= 1'b0;
			out_data_out  <= '0;
		end else if (load) begin
			out_valid_out <= 1'b1;
			out_data_out  <= mem_q[rd_ptr_q];
		end else if (out_ready_in) begin
			out_valid_out <= 1'b0;
		end
	end
endmodule

/* File: logic/spcs_port.sv */
/*
 * spcs_pkg and spcs_port: clock and select pins of a synchronous serial port
 * (SPI, SSI, Microwire) as master or slave, with a 16-word transmit FIFO.
 * Assumes config inputs are steady while a frame runs; pins are asynchronous.
 */
package spcs_pkg;
	localparam logic [1:0] FMT_SPI   = 2'h0;
	localparam logic [1:0] FMT_SSI   = 2'h1;
	localparam logic [1:0] FMT_MWIRE = 2'h2;
	localparam int         WORD_W    = 8;
	localparam int         FIFO_D    = 16;
	localparam int         FIFO_AW   = 4;
	localparam int         CLK_NS    = 10;
	localparam int         HALF_NS   = 60;
	localparam int         HALF_CYC  = (HALF_NS / CLK_NS < 1) ? 1 : HALF_NS / CLK_NS;
	localparam logic [3:0] BITS_LAST = 4'h7;
	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0001,
		ST_LEAD  = 4'b0010,
		ST_SHIFT = 4'b0100,
		ST_TRAIL = 4'b1000
	} spcs_state_t;
endpackage

`timescale 1ns/1ns
module spcs_port import spcs_pkg::*; (
	// clock and reset
	input  wire logic              mclk_in,
	input  wire logic              rst_n_in,
	// configuration
	input  wire logic              enable_in,
	input  wire logic              master_mode_in,
	input  wire logic [1:0]        frame_fmt_in,
	input  wire logic              cpol_in,
	// transmit stream
	input  wire logic              tx_valid_in,
	input  wire logic [WORD_W-1:0] tx_data_in,
	output logic                   tx_ready_out,
	// receive stream
	output logic                   rx_valid_out,
	output logic [WORD_W-1:0]      rx_data_out,
	// serial_clock_pin
	input  wire logic              serial_clock_pin_in,
	output logic                   serial_clock_pin_out,
	output logic                   serial_clock_pin_oe_out,
	// slave_select_frame_sync_pin
	input  wire logic              slave_select_frame_sync_pin_in,
	output logic                   slave_select_frame_sync_pin_out,
	output logic                   slave_select_frame_sync_pin_oe_out,
	// master_out_slave_in_pin
	input  wire logic              master_out_slave_in_pin_in,
	output logic                   master_out_slave_in_pin_out,
	output logic                   master_out_slave_in_pin_oe_out,
	// master_in_slave_out_pin
	input  wire logic              master_in_slave_out_pin_in,
	output logic                   master_in_slave_out_pin_out,
	output logic                   master_in_slave_out_pin_oe_out
);
	//------------------------------------------------------------
	// format decode and transmit buffer
	//------------------------------------------------------------
	spcs_state_t       state_q;
	logic [7:0]        div_q;
	logic              half_tick;
	logic              phase_q;
	logic [3:0]        bit_q;
	logic [WORD_W-1:0] tx_sh_q;
	logic [WORD_W-1:0] rx_sh_q;
	logic              cpol_eff;
	logic              sel_act;
	logic              is_master;
	logic              fifo_valid;
	logic [WORD_W-1:0] fifo_data;
	logic              fifo_pop;
	logic              m_pop;
	logic              s_pop;

	assign cpol_eff  = (frame_fmt_in == FMT_SPI) ? cpol_in : 1'b0;
	assign sel_act   = (frame_fmt_in == FMT_SSI);
	assign is_master = enable_in & master_mode_in;
	assign fifo_pop  = m_pop | s_pop;

	spcs_fifo #(.W(WORD_W), .D(FIFO_D), .AW(FIFO_AW)) spcs_fifo_inst (
		.clk_in       (mclk_in),
		.rst_n_in     (rst_n_in),
		.in_valid_in  (tx_valid_in),
		.in_data_in   (tx_data_in),
		.in_ready_out (tx_ready_out),
		.out_valid_out(fifo_valid),
		.out_data_out (fifo_data),
		.out_ready_in (fifo_pop)
	);

	//------------------------------------------------------------
	// master side
	//------------------------------------------------------------
	// half-period enable; the bit rate is fixed by HALF_CYC
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in || div_q == 8'(HALF_CYC - 1)) begin
			div_q <= '0;
		end else begin
			div_q <= div_q + 8'h01;
		end
	end
	assign half_tick = (div_q == 8'(HALF_CYC - 1));
	assign m_pop     = half_tick && is_master && state_q == ST_IDLE && fifo_valid;

	// frame sequencer: select leads the first clock edge by a full period (two half periods)
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			state_q                         <= ST_IDLE;
			phase_q                         <= 1'b0;
			bit_q                           <= '0;
			serial_clock_pin_out            <= 1'b0;
			slave_select_frame_sync_pin_out <= 1'b1;
		end else if (!is_master) begin
			state_q                         <= ST_IDLE;
			phase_q                         <= 1'b0;
			serial_clock_pin_out            <= cpol_eff;
			slave_select_frame_sync_pin_out <= !sel_act;
		end else if (half_tick) begin
			case (state_q)
				ST_IDLE: begin
					serial_clock_pin_out <= cpol_eff;
					if (fifo_valid) begin
						slave_select_frame_sync_pin_out <= sel_act;
						state_q                         <= ST_LEAD;
					end
				end
				ST_LEAD: begin
					// frame sync is a single pulse ahead of the data
					if (sel_act) begin
						slave_select_frame_sync_pin_out <= 1'b0;
					end
					bit_q   <= '0;
					phase_q <= 1'b0;
					state_q <= ST_SHIFT;
				end
				ST_SHIFT: begin
					phase_q              <= !phase_q;
					serial_clock_pin_out <= cpol_eff ^ !phase_q;
					if (phase_q) begin
						bit_q <= bit_q + 4'h1;
						if (bit_q == BITS_LAST) begin
							state_q <= ST_TRAIL;
						end
					end
				end
				ST_TRAIL: begin
					slave_select_frame_sync_pin_out <= !sel_act;
					state_q                         <= ST_IDLE;
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end else if (state_q == ST_IDLE) begin
			// idle levels follow a format or polarity change at once, not a tick later
			serial_clock_pin_out            <= cpol_eff;
			slave_select_frame_sync_pin_out <= !sel_act;
		end
	end

	//------------------------------------------------------------
	// pin synchronisers and slave side
	//------------------------------------------------------------
	logic [1:0] sck_s_q;
	logic [1:0] sel_s_q;
	logic [1:0] mosi_s_q;
	logic [1:0] miso_s_q;
	logic       sck_d_q;
	logic       s_lead;
	logic       s_trail;
	logic       ssi_arm_q;
	logic       s_sel;
	logic       s_sel_q;
	logic [3:0] s_bit_q;

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			sck_s_q  <= '0;
			sel_s_q  <= 2'h3;
			mosi_s_q <= '0;
			miso_s_q <= '0;
			sck_d_q  <= 1'b0;
		end else begin
			sck_s_q  <= {sck_s_q[0], serial_clock_pin_in};
			sel_s_q  <= {sel_s_q[0], slave_select_frame_sync_pin_in};
			mosi_s_q <= {mosi_s_q[0], master_out_slave_in_pin_in};
			miso_s_q <= {miso_s_q[0], master_in_slave_out_pin_in};
			sck_d_q  <= sck_s_q[1];
		end
	end

	// edges of the incoming clock, seen only as a slave
	assign s_lead  = !is_master && enable_in && sck_d_q == cpol_eff && sck_s_q[1] != cpol_eff;
	assign s_trail = !is_master && enable_in && sck_d_q != cpol_eff && sck_s_q[1] == cpol_eff;
	assign s_sel   = sel_act ? ssi_arm_q : !sel_s_q[1];
	assign s_pop   = !is_master && s_sel && !s_sel_q && fifo_valid;

	// ssi: a frame sync seen at a clock edge opens the next word
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in || is_master) begin
			ssi_arm_q <= 1'b0;
		end else if (s_lead && sel_s_q[1] && !ssi_arm_q) begin
			ssi_arm_q <= 1'b1;
		end else if (s_lead && s_bit_q == BITS_LAST) begin
			ssi_arm_q <= 1'b0;
		end
	end

	// shift registers, shared by both roles
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			tx_sh_q      <= '0;
			rx_sh_q      <= '0;
			s_bit_q      <= '0;
			s_sel_q      <= 1'b0;
			rx_valid_out <= 1'b0;
			rx_data_out  <= '0;
		end else begin
			rx_valid_out <= 1'b0;
			s_sel_q      <= s_sel && !is_master;
			if (m_pop) begin
				tx_sh_q <= fifo_data;
			end else if (is_master && half_tick && state_q == ST_SHIFT) begin
				if (!phase_q) begin
					rx_sh_q <= {rx_sh_q[WORD_W-2:0], miso_s_q[1]};
				end else begin
					tx_sh_q <= {tx_sh_q[WORD_W-2:0], 1'b0};
					if (bit_q == BITS_LAST) begin
						rx_valid_out <= 1'b1;
						rx_data_out  <= rx_sh_q;
					end
				end
			end else if (!is_master && s_sel && !s_sel_q) begin
				// unloaded fifo sends zeros rather than stalling the master
				tx_sh_q <= fifo_valid ? fifo_data : '0;
				s_bit_q <= '0;
			end else if (s_lead && s_sel && !(sel_act && !s_sel_q)) begin
				rx_sh_q <= {rx_sh_q[WORD_W-2:0], mosi_s_q[1]};
				s_bit_q <= s_bit_q + 4'h1;
				if (s_bit_q == BITS_LAST) begin
					rx_valid_out <= 1'b1;
					rx_data_out  <= {rx_sh_q[WORD_W-2:0], mosi_s_q[1]};
					s_bit_q      <= '0;
				end
			end else if (s_trail && s_sel && s_bit_q != '0) begin
				tx_sh_q <= {tx_sh_q[WORD_W-2:0], 1'b0};
			end
		end
	end

	// pin drivers and enables
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			serial_clock_pin_oe_out            <= 1'b0;
			slave_select_frame_sync_pin_oe_out <= 1'b0;
			master_out_slave_in_pin_out        <= 1'b0;
			master_out_slave_in_pin_oe_out     <= 1'b0;
			master_in_slave_out_pin_out        <= 1'b0;
			master_in_slave_out_pin_oe_out     <= 1'b0;
		end else begin
			serial_clock_pin_oe_out            <= is_master;
			slave_select_frame_sync_pin_oe_out <= is_master;
			master_out_slave_in_pin_oe_out     <= is_master;
			master_out_slave_in_pin_out        <= tx_sh_q[WORD_W-1];
			master_in_slave_out_pin_oe_out     <= !is_master && s_sel;
			master_in_slave_out_pin_out        <= tx_sh_q[WORD_W-1];
		end
	end

	//------------------------------------------------------------
	// checks
	//------------------------------------------------------------
	slave_clk_release_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		!is_master |=> !serial_clock_pin_oe_out) else $error("slave drives clock");
	spi_idle_level_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		is_master && state_q == ST_LEAD |-> serial_clock_pin_out == cpol_eff) else $error("bad idle level");
	clock_in_frame_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		is_master && $stable(cpol_eff) && $past(cpol_eff, 2) == cpol_eff && $changed(serial_clock_pin_out)
		|-> $past(state_q) == ST_SHIFT)
		else $error("clock moved outside frame");
	idle_clock_hold_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		is_master && $past(is_master) && state_q == ST_IDLE && $past(state_q) == ST_IDLE && $stable(cpol_eff)
		|-> serial_clock_pin_out == cpol_eff && serial_clock_pin_oe_out) else $error("idle clock moved");
	select_leads_data_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		is_master && !sel_act && state_q == ST_SHIFT |-> !slave_select_frame_sync_pin_out)
		else $error("select not active in frame");
	select_release_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		is_master && !sel_act && state_q == ST_TRAIL |-> ##[1:8] slave_select_frame_sync_pin_out)
		else $error("select not released");
	ssi_sync_pulse_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		is_master && sel_act && $rose(slave_select_frame_sync_pin_out)
		|-> ##[1:8] !slave_select_frame_sync_pin_out) else $error("frame sync too long");
	slave_word_qual_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		!is_master && !sel_act && sel_s_q[1] && $past(sel_s_q[1]) |-> !rx_valid_out)
		else $error("word without select");
	miso_float_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		!s_sel |=> !master_in_slave_out_pin_oe_out) else $error("miso driven unselected");
	mosi_direction_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		is_master |=> master_out_slave_in_pin_oe_out && !master_in_slave_out_pin_oe_out)
		else $error("data pin direction");
endmodule

/* File: test/spcs_far_end.sv */
/*
 * spcs_far_end: behavioural far-side device of the serial port, slave or master.
 * Assumes the bench resolves every pin from the design's enables.
 */
`timescale 1ns/1ns
module spcs_far_end (
	// role and format
	input  wire logic       dut_master_in,
	input  wire logic [1:0] fmt_in,
	input  wire logic       pol_in,
	input  wire logic [7:0] reply_in,
	// resolved lines
	input  wire logic       sck_in,
	input  wire logic       sel_in,
	input  wire logic       mosi_in,
	input  wire logic       miso_in,
	// our own drive
	output logic            sck_out,
	output logic            sel_out,
	output logic            mosi_out,
	output logic            miso_out
);
	logic [7:0] sh = '0, got = '0, rcv = '0;
	logic       on = 0, tg = 0, drv = 0, cs = 0, ss = 0, mb = 0;
	int         nb = 0;
	wire        act  = (fmt_in == 2'h1);
	wire        lead = sck_in ^ pol_in;
	wire        fsa  = act ? sel_in : !sel_in;

	// released data lines show a moving pattern, never a stale bit
	always #20 tg = ~tg;
	assign sck_out  = drv ? cs : pol_in;
	assign sel_out  = drv ? ss : ~act;
	assign mosi_out = drv ? mb : tg;
	assign miso_out = on ? sh[7] : tg;

	// ----------------------------------------
	// slave role: the design clocks us
	// ----------------------------------------
	always @(posedge fsa) if (dut_master_in) begin
		sh = reply_in;
		nb = 0;
		on = 1;
	end
	always @(negedge fsa) if (!act) on = 0;
	// sample on leading edge; frame sync runs out after eight bits
	always @(posedge lead) if (dut_master_in && on) begin
		got = {got[6:0], mosi_in};
		nb++;
		if (act && nb == 8) on = 0;
	end
	always @(negedge lead) if (dut_master_in && on) sh = {sh[6:0], 1'b0};

	// ----------------------------------------
	// master role: we make the 125 ns clock
	// ----------------------------------------
	task send(input logic [7:0] w);
		int i;
		cs  = pol_in;
		ss  = act;
		drv = 1;
		// frame sync is one clock wide for the pulsed format
		if (act) begin
			#62 cs = ~pol_in;
			#63 cs = pol_in;
			ss = 0;
		end else #125;
		for (i = 7; i >= 0; i--) begin
			mb = w[i];
			#62 cs = ~pol_in;
			rcv = {rcv[6:0], miso_in};
			#63 cs = pol_in;
		end
		#62 ss = ~act;
		#63 drv = 0;
	endtask
endmodule

/* File: test/test_serial_port_clock_select_pins.sv */
/*
 * test_serial_port_clock_select_pins: scenarios for the serial port pins.
 * Assumes spcs_port and spcs_far_end compiled before this file.
 */
`timescale 1ns/1ns
module test_serial_port_clock_select_pins;
	import spcs_pkg::*;
	logic             clk, rst_n, en, mm, pol, tv;
	logic [1:0]       fmt;
	logic [7:0]       td, reply;
	wire              tr, rv, sck_o, sck_oe, sel_o, sel_oe, mo_o, mo_oe, mi_o, mi_oe;
	wire              p_sck, p_sel, p_mo, p_mi;
	wire [WORD_W-1:0] rd;
	int               err_count = 0, n_tests = 0, ntog = 0;
	logic             saw = 0, ok5 = 0;
	logic [1:0]       fl[6] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2};
	logic             pl[6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
	// pin resolution from the design's enables
	wire sck  = sck_oe ? sck_o : p_sck;
	wire sel  = sel_oe ? sel_o : p_sel;
	wire mosi = mo_oe ? mo_o : p_mo;
	wire miso = mi_oe ? mi_o : p_mi;

	spcs_port spcs_port_inst (.mclk_in(clk), .rst_n_in(rst_n), .enable_in(en), .master_mode_in(mm),
		.frame_fmt_in(fmt), .cpol_in(pol), .tx_valid_in(tv), .tx_data_in(td), .tx_ready_out(tr),
		.rx_valid_out(rv), .rx_data_out(rd), .serial_clock_pin_in(sck), .serial_clock_pin_out(sck_o),
		.serial_clock_pin_oe_out(sck_oe), .slave_select_frame_sync_pin_in(sel),
		.slave_select_frame_sync_pin_out(sel_o), .slave_select_frame_sync_pin_oe_out(sel_oe),
		.master_out_slave_in_pin_in(mosi), .master_out_slave_in_pin_out(mo_o),
		.master_out_slave_in_pin_oe_out(mo_oe), .master_in_slave_out_pin_in(miso),
		.master_in_slave_out_pin_out(mi_o), .master_in_slave_out_pin_oe_out(mi_oe));
	spcs_far_end spcs_far_end_inst (.dut_master_in(mm), .fmt_in(fmt), .pol_in(pol & (fmt == 2'h0)),
		.reply_in(reply), .sck_in(sck), .sel_in(sel), .mosi_in(mosi), .miso_in(miso),
		.sck_out(p_sck), .sel_out(p_sel), .mosi_out(p_mo), .miso_out(p_mi));

	// ----------------------------------------
	// clock and pin monitors
	// ----------------------------------------
	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	// every clock pin change counted; select activity noted before the first
	always @(sck_o) begin
		if (ntog == 0) ok5 = saw;
		ntog++;
	end
	always @(sel_o) if (sel_o === (fmt == 2'h1)) saw = 1;

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task chk(input logic ok, input string m);
		n_tests++;
		if (ok !== 1'b1) begin
			err_count++;
			$display("wrong value at %0t ns: %s", $time, m);
		end
	endtask
	task step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task tally_and_finish();
		$display("checks %0d, mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// bounded wait for the one-cycle receive pulse
	task wait_rx();
		int i;
		for (i = 0; i < 600 && rv !== 1'b1; i++) step(1);
		if (i == 600) begin
			chk(1'b0, "no word received");
			tally_and_finish();
		end
	endtask
	task push(input logic [7:0] w);
		int i;
		for (i = 0; i < 50 && tr !== 1'b1; i++) step(1);
		if (i == 50) begin
			chk(1'b0, "fifo never ready");
			tally_and_finish();
		end
		tv = 1;
		td = w;
		step(1);
		tv = 0;
	endtask
	// config settles first, so an idle-level change is not counted
	task cfg(input logic m, input logic [1:0] f, input logic p);
		en  = 1;
		mm  = m;
		fmt = f;
		pol = p;
		step(6);
		ntog = 0;
		saw  = 0;
		ok5  = 0;
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task master_frame(input logic [1:0] f, input logic p, input logic [7:0] w, input logic [7:0] r);
		reply = r;
		cfg(1'b1, f, p);
		push(w);
		wait_rx();
		chk(rd === r, "master receive word");
		step(40);
		chk(spcs_far_end_inst.got === w, "mosi bits");
		chk(ntog == 16, "clock edge count");
		chk(ok5 === 1'b1, "select active before first clock");
		chk(sel_o === (f != 2'h1), "select idle level");
		chk(sck_o === (p & (f == 2'h0)) && sck_oe === 1'b1, "clock idle level");
		chk(sel_oe === 1'b1 && mo_oe === 1'b1 && mi_oe === 1'b0, "master pin directions");
	endtask
	task slave_frame(input logic [1:0] f, input logic p, input logic [7:0] wt, input logic [7:0] wr);
		cfg(1'b0, f, p);
		push(wt);
		chk(sck_oe === 1'b0, "slave drives clock");
		chk(mi_oe === 1'b0, "unselected slave drives miso");
		fork
			spcs_far_end_inst.send(wr);
			wait_rx();
		join
		chk(rd === wr, "slave receive word");
		if (f != 2'h1) chk(spcs_far_end_inst.rcv === wt, "slave reply word");
		step(10);
		if (f != 2'h1) chk(mi_oe === 1'b0, "miso released after frame");
	endtask
	// fill while disabled until refused, then drain as master
	task fill_drain();
		int i, n;
		en    = 0;
		mm    = 1;
		fmt   = 2'h0;
		reply = 8'h5e;
		step(4);
		n = 0;
		for (i = 0; i < 20 && tr === 1'b1; i++) begin
			tv = 1;
			td = i[7:0];
			step(1);
			tv = 0;
			step(2);
			n++;
		end
		chk(n == FIFO_D && tr === 1'b0, "fifo fill depth");
		en = 1;
		n  = 0;
		for (i = 0; i < 4000 && n < FIFO_D; i++) begin
			step(1);
			if (rv === 1'b1) n++;
		end
		chk(n == FIFO_D && tr === 1'b1, "fifo drained");
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		rst_n = 0;
		en    = 0;
		mm    = 1;
		fmt   = 2'h0;
		pol   = 0;
		tv    = 0;
		td    = '0;
		reply = '0;
		repeat (8) @(posedge clk);
		#1;
		chk(sck_oe === 1'b0 && sel_oe === 1'b0 && mi_oe === 1'b0 && mo_oe === 1'b0, "pins in reset");
		chk(sel_o === 1'b1 && tr === 1'b0, "select and ready in reset");
		rst_n = 1;
		step(2);
		chk(tr === 1'b1, "ready after reset");
		for (int k = 0; k < 6; k++) master_frame(fl[k], pl[k], 8'h96 ^ 8'(k), 8'h3c + 8'(k));
		for (int k = 0; k < 6; k++) slave_frame(fl[k], pl[k], 8'hc3 - 8'(k), 8'h5a ^ 8'(k));
		fill_drain();
		tally_and_finish();
	end
endmodule
